/* verilog/bpb_cfg.svh */
/*
  Address, reset and field constants of the three-port I/O block.
  Assumes it is included by bare name and that data memory addresses are 8 bits.
*/
`ifndef BPB_CFG_SVH
`define BPB_CFG_SVH

// ----------------------------------------
// Data memory addresses
// ----------------------------------------
`define BPB_ADDR_A_DATA 8'h12
`define BPB_ADDR_A_DIR 8'h13
`define BPB_ADDR_B_DATA 8'h14
`define BPB_ADDR_B_DIR 8'h15
`define BPB_ADDR_C_DATA 8'h16
`define BPB_ADDR_C_DIR 8'h17

// ----------------------------------------
// Reset values: latches high, every line an input
// ----------------------------------------
`define BPB_RST_A 8'hFF
`define BPB_RST_B 3'h7
`define BPB_RST_C 2'h3
`define BPB_RD_IDLE 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BPB_BZ_BIT 0
`define BPB_BZN_BIT 1
`define BPB_IRQ_BIT 0
`define BPB_CNT_BIT 1
`define BPB_SYNC_W 16

`endif

/* verilog/bpb_pkg.sv */
/*
  Types shared by the three-port I/O block.
  Assumes the includer also reads bpb_cfg.svh for the constants.
*/
package bpb_pkg;

  // Thirteen lines: eight on port A, three on B, two on C
  typedef struct packed {
    logic [7:0] a;
    logic [2:0] b;
    logic [1:0] c;
  } bpb_pads_t;

  // Data memory access from the core, sampled at the T2 edge
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bpb_bus_t;

  // Mask options, static straps
  typedef struct packed {
    logic pull_high;
    logic buzzer;
    logic wake;
  } bpb_opt_t;

  typedef struct packed {
    bpb_pads_t data;
    bpb_pads_t dir;
    logic [7:0] rd_data;
    bpb_pads_t pad_out;
    bpb_pads_t pad_oe;
    logic pull_up;
    logic wake;
    logic [2:0] armed;
    logic [7:0] a_prev;
    logic irq_line;
    logic cnt_line;
  } bpb_state_t;

endpackage

/* verilog/bpb_sync.sv */
/*
  Two-flop synchroniser for pad levels and option straps.
  Assumes inputs are slow levels; the first flop feeds only the second.
*/
`timescale 1ns/10ps
module bpb_sync #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } bpb_sync_t;

  bpb_sync_t st_r;
  bpb_sync_t st_nxt;

  always_comb begin
    st_nxt.meta = async_i;
    st_nxt.stable = st_r.meta;
    if (!resetn_i) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  assign sync_o = st_r.stable;
endmodule

/* verilog/bpb_tone.sv */
/*
  Tone divider: halves the timer overflow rate into a square wave.
  Assumes the overflow pulse is one cycle wide on the same clock.
*/
`timescale 1ns/10ps
module bpb_tone (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic overflow_i,
  output logic tone_o
);
  typedef struct packed {
    logic tone;
  } bpb_tone_t;

  bpb_tone_t st_r;
  bpb_tone_t st_nxt;

  // Toggling per overflow gives f_timer / (2 x (256 - preload))
  always_comb begin
    st_nxt = st_r;
    if (overflow_i) begin
      st_nxt.tone = ~st_r.tone;
    end
    if (!resetn_i) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  assign tone_o = st_r.tone;

  tone_toggle_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    overflow_i |=> tone_o != $past(tone_o))
    else $error("tone did not toggle on overflow");

  tone_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !overflow_i |=> $stable(tone_o))
    else $error("tone changed without overflow");
endmodule

/* verilog/bpb_port_top.sv */
/*
  Three memory-mapped bidirectional ports with buzzer pair and wake-up.
  Assumes the core presents one read or write strobe per instruction at its
  T2 edge, and a one-cycle timer overflow pulse on the same clock.
*/
`timescale 1ns/10ps
`include "bpb_cfg.svh"

module bpb_port_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire bpb_pkg::bpb_bus_t bus_i,
  input wire bpb_pkg::bpb_pads_t pad_in_i,
  input wire bpb_pkg::bpb_opt_t opt_i,
  input wire logic timer_ovf_i,
  output logic [7:0] rd_data_o,
  output bpb_pkg::bpb_pads_t pad_out_o,
  output bpb_pkg::bpb_pads_t pad_oe_o,
  output logic pull_up_o,
  output logic wake_o,
  output logic irq_line_o,
  output logic counter_line_o
);

  // ----------------------------------------
  // Pad and strap synchronisation
  // ----------------------------------------
  logic [`BPB_SYNC_W-1:0] sync_w;
  bpb_pkg::bpb_pads_t pads_s;
  bpb_pkg::bpb_opt_t opt_s;
  logic tone_w;

  bpb_sync #(
    .W(`BPB_SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i({opt_i, pad_in_i}),
    .sync_o(sync_w)
  );

  assign pads_s = sync_w[12:0];
  assign opt_s = sync_w[15:13];

  bpb_tone u_tone (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .overflow_i(timer_ovf_i),
    .tone_o(tone_w)
  );

  // ----------------------------------------
  // Read mixing
  // ----------------------------------------
  // Output bits return the latch so a read-modify-write never copies a
  // loaded pad level back into the latch.
  function automatic logic [7:0] port_mix(
    input logic [7:0] dir,
    input logic [7:0] latch,
    input logic [7:0] pad
  );
    port_mix = (dir & pad) | (~dir & latch);
  endfunction

  bpb_pkg::bpb_state_t st_r;
  bpb_pkg::bpb_state_t st_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;

    // Writes land only in implemented bits
    if (bus_i.wr) begin
      if (bus_i.addr == `BPB_ADDR_A_DATA) begin
        st_nxt.data.a = bus_i.wdata;
      end else if (bus_i.addr == `BPB_ADDR_A_DIR) begin
        st_nxt.dir.a = bus_i.wdata;
      end else if (bus_i.addr == `BPB_ADDR_B_DATA) begin
        st_nxt.data.b = bus_i.wdata[2:0];
      end else if (bus_i.addr == `BPB_ADDR_B_DIR) begin
        st_nxt.dir.b = bus_i.wdata[2:0];
      end else if (bus_i.addr == `BPB_ADDR_C_DATA) begin
        st_nxt.data.c = bus_i.wdata[1:0];
      end else if (bus_i.addr == `BPB_ADDR_C_DIR) begin
        st_nxt.dir.c = bus_i.wdata[1:0];
      end
    end

    // Reads sample the synchronised pads in the strobe cycle
    if (bus_i.rd) begin
      if (bus_i.addr == `BPB_ADDR_A_DATA) begin
        st_nxt.rd_data = port_mix(st_r.dir.a, st_r.data.a, pads_s.a);
      end else if (bus_i.addr == `BPB_ADDR_A_DIR) begin
        st_nxt.rd_data = st_r.dir.a;
      end else if (bus_i.addr == `BPB_ADDR_B_DATA) begin
        st_nxt.rd_data = port_mix({5'h00, st_r.dir.b}, {5'h00, st_r.data.b},
                                  {5'h00, pads_s.b});
      end else if (bus_i.addr == `BPB_ADDR_B_DIR) begin
        st_nxt.rd_data = {5'h00, st_r.dir.b};
      end else if (bus_i.addr == `BPB_ADDR_C_DATA) begin
        st_nxt.rd_data = port_mix({6'h00, st_r.dir.c}, {6'h00, st_r.data.c},
                                  {6'h00, pads_s.c});
      end else if (bus_i.addr == `BPB_ADDR_C_DIR) begin
        st_nxt.rd_data = {6'h00, st_r.dir.c};
      end else begin
        st_nxt.rd_data = `BPB_RD_IDLE;
      end
    end

    // Pad drive follows the direction bits one cycle later
    st_nxt.pad_oe.a = ~st_r.dir.a;
    st_nxt.pad_oe.b = ~st_r.dir.b;
    st_nxt.pad_oe.c = ~st_r.dir.c;
    st_nxt.pad_out = st_r.data;

    if (opt_s.buzzer) begin
      // Bit 0 latch gates both lines, whatever bit 0 direction is
      st_nxt.pad_out.b[`BPB_BZ_BIT] = st_r.data.b[`BPB_BZ_BIT] & tone_w;
      st_nxt.pad_out.b[`BPB_BZN_BIT] = st_r.data.b[`BPB_BZ_BIT] & ~tone_w;
    end

    st_nxt.pull_up = opt_s.pull_high;

    // Wake on any change of a port A input line. The synchroniser is cleared
    // by reset and refills two edges later; arming waits three edges so that
    // refill is never taken for a pin change.
    st_nxt.a_prev = pads_s.a;
    st_nxt.armed = {st_r.armed[1:0], 1'b1};
    st_nxt.wake = opt_s.wake & st_r.armed[2] & |((pads_s.a ^ st_r.a_prev) & st_r.dir.a);

    st_nxt.irq_line = pads_s.c[`BPB_IRQ_BIT];
    st_nxt.cnt_line = pads_s.c[`BPB_CNT_BIT];

    if (!resetn_i) begin
      st_nxt = '0;
      st_nxt.data = {`BPB_RST_A, `BPB_RST_B, `BPB_RST_C};
      st_nxt.dir = {`BPB_RST_A, `BPB_RST_B, `BPB_RST_C};
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rd_data_o = st_r.rd_data;
  assign pad_out_o = st_r.pad_out;
  assign pad_oe_o = st_r.pad_oe;
  assign pull_up_o = st_r.pull_up;
  assign wake_o = st_r.wake;
  assign irq_line_o = st_r.irq_line;
  assign counter_line_o = st_r.cnt_line;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  reset_inputs_a: assert property (@(posedge clk_i) disable iff (1'b0)
    !resetn_i |=> (pad_oe_o == '0) && (st_r.dir == '1) && (st_r.data == '1))
    else $error("lines not inputs after reset");

  latch_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.wr && bus_i.addr == `BPB_ADDR_A_DATA
    |=> st_r.data.a == $past(bus_i.wdata) ##1 pad_out_o.a == $past(st_r.data.a))
    else $error("port A write not latched and driven");

  latch_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !(bus_i.wr && bus_i.addr == `BPB_ADDR_A_DATA) |=> $stable(st_r.data.a))
    else $error("port A latch changed without write");

  read_mix_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.rd && bus_i.addr == `BPB_ADDR_A_DATA
    |=> rd_data_o == (($past(pads_s.a) & $past(st_r.dir.a))
                      | ($past(st_r.data.a) & ~$past(st_r.dir.a))))
    else $error("port A read mix wrong");

  unimpl_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.rd && (bus_i.addr == `BPB_ADDR_B_DATA || bus_i.addr == `BPB_ADDR_C_DATA)
    |=> rd_data_o[7:3] == 5'h00 && (!$past(bus_i.addr[1]) || rd_data_o[2] == 1'b0))
    else $error("unimplemented bits read nonzero");

  out_enable_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $stable(st_r.dir) |-> pad_oe_o == ~st_r.dir)
    else $error("output enable disagrees with direction");

  buzz_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    opt_s.buzzer && !st_r.data.b[0] ##1 $stable(opt_s) && $stable(st_r.data.b)
    |-> pad_out_o.b[1:0] == 2'h0)
    else $error("buzzer lines not low with bit 0 clear");

  buzz_pair_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    opt_s.buzzer && st_r.data.b[0] ##1 $stable(opt_s) && $stable(st_r.data.b)
    |-> pad_out_o.b[1] == ~pad_out_o.b[0])
    else $error("buzzer pair not complementary");

  plain_b_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !opt_s.buzzer ##1 $stable(opt_s) && $stable(st_r.data.b)
    |-> pad_out_o.b == st_r.data.b)
    else $error("port B not plain without buzzer");

  wake_opt_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wake_o |-> $past(opt_s.wake) && $past(st_r.dir.a) != 8'h00)
    else $error("wake without option or input line");

  pull_all_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ##1 pull_up_o == $past(opt_s.pull_high))
    else $error("pull-up does not follow option");

  shared_c_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ##1 irq_line_o == $past(pads_s.c[0]) && counter_line_o == $past(pads_s.c[1]))
    else $error("shared port C lines not forwarded");

  // ----------------------------------------
  // Register map checks
  // ----------------------------------------
  // Narrow ports keep only their implemented bits, whatever the core writes
  latch_write_b_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.wr && bus_i.addr == `BPB_ADDR_B_DATA |=> st_r.data.b == $past(bus_i.wdata[2:0]))
    else $error("port B write not latched");

  latch_write_c_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.wr && bus_i.addr == `BPB_ADDR_C_DATA |=> st_r.data.c == $past(bus_i.wdata[1:0]))
    else $error("port C write not latched");

  dir_write_a_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.wr && bus_i.addr == `BPB_ADDR_A_DIR |=> st_r.dir.a == $past(bus_i.wdata))
    else $error("port A direction write lost");

  dir_write_c_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.wr && bus_i.addr == `BPB_ADDR_C_DIR |=> st_r.dir.c == $past(bus_i.wdata[1:0]))
    else $error("port C direction write lost");

  dir_read_b_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.rd && bus_i.addr == `BPB_ADDR_B_DIR |=> rd_data_o == {5'h00, $past(st_r.dir.b)})
    else $error("port B direction read wrong");

  dir_read_a_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.rd && bus_i.addr == `BPB_ADDR_A_DIR |=> rd_data_o == $past(st_r.dir.a))
    else $error("port A direction read wrong");

  // Addresses outside the six registers answer zero
  unmapped_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.rd && (bus_i.addr < `BPB_ADDR_A_DATA || bus_i.addr > `BPB_ADDR_C_DIR)
    |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");

  // Read data stands between reads so the core may take it late
  read_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !bus_i.rd |=> $stable(rd_data_o))
    else $error("read data changed without read");

  wake_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !opt_s.wake |=> !wake_o)
    else $error("wake with option disabled");

  wake_output_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wake_o |-> $past(st_r.armed[2]))
    else $error("wake before synchroniser refilled");

  write_a_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.wr && bus_i.addr == `BPB_ADDR_A_DATA ##1 bus_i.rd);
  buzz_on_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    opt_s.buzzer && st_r.data.b[0] && pad_out_o.b[0]);
  wake_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    wake_o);
  read_b_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.rd && bus_i.addr == `BPB_ADDR_B_DATA);
  read_c_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    bus_i.rd && bus_i.addr == `BPB_ADDR_C_DATA);

endmodule

/* bench/bpb_pad_model.sv */
/*
  Board model: resolves each line from the block's drive, an external source,
  the pull-high resistors or a floating level.
  Assumes one clock; external sources yield wherever the block drives.
*/
`timescale 1ns/10ps
module bpb_pad_model (
  input wire logic clk_i,
  input wire bpb_pkg::bpb_pads_t pad_out_i,
  input wire bpb_pkg::bpb_pads_t pad_oe_i,
  input wire logic pull_up_i,
  input wire bpb_pkg::bpb_pads_t ext_val_i,
  input wire bpb_pkg::bpb_pads_t ext_en_i,
  output bpb_pkg::bpb_pads_t pad_o
);
  // ----------------------------------------
  // Line resolution
  // ----------------------------------------
  // Floating lines toggle every cycle so a stale level never reads as valid
  logic [12:0] float_r = 13'h0000;

  always @(posedge clk_i) begin
    float_r <= ~float_r;
  end

  always_comb begin
    for (int i = 0; i < 13; i++) begin
      if (pad_oe_i[i]) begin
        pad_o[i] = pad_out_i[i];
      end else if (ext_en_i[i]) begin
        pad_o[i] = ext_val_i[i];
      end else begin
        pad_o[i] = pull_up_i | float_r[i];
      end
    end
  end
endmodule

/* bench/tb_bidir_port_with_buzzer_pair.sv */
/*
  Self-checking bench for the three-port I/O block.
  Assumes bpb_pkg is compiled first and the pad model stands in for the board.
*/
`timescale 1ns/10ps
module tb_bidir_port_with_buzzer_pair;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic timer_ovf_i = 1'b0;
  bpb_pkg::bpb_bus_t bus_i = '0;
  bpb_pkg::bpb_opt_t opt_i = '0;
  bpb_pkg::bpb_pads_t ext_val = '0;
  bpb_pkg::bpb_pads_t ext_en = '1;
  bpb_pkg::bpb_pads_t pad_in_i, pad_out_o, pad_oe_o, exp_lat, exp_dir;
  logic [7:0] rd_data_o;
  logic pull_up_o, wake_o, irq_line_o, counter_line_o;
  int errors = 0;
  int comparisons = 0;
  int seed = 12840;
  int n;
  logic [31:0] r;

  always #10 clk_i = ~clk_i;

  bpb_port_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .pad_in_i(pad_in_i),
    .opt_i(opt_i), .timer_ovf_i(timer_ovf_i), .rd_data_o(rd_data_o), .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o), .pull_up_o(pull_up_o), .wake_o(wake_o), .irq_line_o(irq_line_o),
    .counter_line_o(counter_line_o));

  bpb_pad_model pads (.clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .pull_up_i(pull_up_o), .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_o(pad_in_i));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task results;
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  // Pad level seen by the block: external source, else pull-high option
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    logic [12:0] p;
    logic [12:0] v;
    p = (ext_val & ext_en) | (~ext_en & {13{opt_i.pull_high}});
    v = (p & exp_dir) | (exp_lat & ~exp_dir);
    case (a)
      8'h12: return v[12:5];
      8'h13: return exp_dir.a;
      8'h14: return {5'h00, v[4:2]};
      8'h15: return {5'h00, exp_dir.b};
      8'h16: return {6'h00, v[1:0]};
      8'h17: return {6'h00, exp_dir.c};
      default: return 8'h00;
    endcase
  endfunction

  // Waits long enough for a new drive to cross the pad synchronisers
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc(1);
    bus_i.wr = 1'b0;
    case (a)
      8'h12: exp_lat.a = d;
      8'h13: exp_dir.a = d;
      8'h14: exp_lat.b = d[2:0];
      8'h15: exp_dir.b = d[2:0];
      8'h16: exp_lat.c = d[1:0];
      8'h17: exp_dir.c = d[1:0];
      default: ;
    endcase
    cyc(4);
  endtask

  task rd_chk(input logic [7:0] a);
    bus_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    bus_i.rd = 1'b0;
    chk(rd_data_o, exp_rd(a));
    cyc(1);
  endtask

  task pads_chk;
    chk(pad_oe_o, ~exp_dir);
    chk(pad_out_o & pad_oe_o, exp_lat & ~exp_dir);
  endtask

  task tone_chk(input logic [1:0] oe, input logic on);
    logic flip;
    flip = on & ~pad_out_o.b[1];
    timer_ovf_i = 1'b1;
    cyc(1);
    timer_ovf_i = 1'b0;
    cyc(3);
    chk(pad_out_o.b[1], flip);
    chk(pad_out_o.b[0], on & ~flip);
    chk(pad_oe_o.b[1:0], oe);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    exp_lat = '1;
    exp_dir = '1;
    r = $random(seed);
    ext_val = r[12:0];
    cyc(10);
    resetn_i = 1'b1;
    cyc(4);
    chk(pad_oe_o, 13'h0000);
    for (n = 0; n < 6; n++) begin
      rd_chk(8'h12 + n[7:0]);
    end
    for (n = 0; n < 60; n++) begin
      r = $random(seed);
      ext_val = r[28:16];
      wr(8'h11 + {5'h00, r[2:0]}, r[15:8]);
      rd_chk(8'h11 + {5'h00, r[5:3]});
      pads_chk();
    end
    wr(8'h13, 8'hF0);
    rd_chk(8'h12);
    wr(8'h12, exp_rd(8'h12) | 8'h01);
    wr(8'h13, 8'h00);
    pads_chk();
    wr(8'h13, 8'hFF);
    opt_i.pull_high = 1'b1;
    ext_en.a = 8'h00;
    // Pull-up needs three edges to reach the pin, then two more to be sampled
    cyc(5);
    chk(pull_up_o, 1'b1);
    rd_chk(8'h12);
    ext_en = '1;
    opt_i.pull_high = 1'b0;
    for (n = 0; n < 2; n++) begin
      opt_i.wake = ~n[0];
      cyc(4);
      ext_val.a[3] = ~ext_val.a[3];
      r = 0;
      repeat (8) begin
        cyc(1);
        r = r + wake_o;
      end
      chk(r[12:0], {12'h000, ~n[0]});
    end
    wr(8'h17, 8'hFF);
    for (n = 0; n < 4; n++) begin
      ext_val.c = n[1:0];
      cyc(4);
      chk({counter_line_o, irq_line_o}, n[1:0]);
    end
    opt_i.buzzer = 1'b1;
    wr(8'h15, 8'h00);
    wr(8'h14, 8'h01);
    for (n = 0; n < 3; n++) begin
      tone_chk(2'h3, 1'b1);
    end
    wr(8'h15, 8'h01);
    tone_chk(2'h2, 1'b1);
    wr(8'h15, 8'h00);
    wr(8'h14, 8'h00);
    tone_chk(2'h3, 1'b0);
    opt_i.buzzer = 1'b0;
    wr(8'h14, 8'h02);
    pads_chk();
    // Park every line as an output so no input is left floating
    wr(8'h13, 8'h00);
    wr(8'h15, 8'h00);
    wr(8'h17, 8'h00);
    pads_chk();
    results();
  end

  // Whole run is about 590 cycles; this allows some seventeen times that
  initial begin
    #200000;
    errors++;
    results();
  end
endmodule
